// File: rtl/tfc_params.svh
// Constants of the thermal fan control pin block
`ifndef TFC_PARAMS_SVH
`define TFC_PARAMS_SVH

`define TFC_CLK_PERIOD_NS  100
`define TFC_RRST_TIME_NS   10000
`define TFC_RRST_CYCLES    ((`TFC_RRST_TIME_NS + `TFC_CLK_PERIOD_NS - 1) / `TFC_CLK_PERIOD_NS)

`define TFC_SMB_ADDR       7'h2e

`define TFC_REG_CONFIG     8'h40
`define TFC_REG_STATUS     8'h41
`define TFC_REG_MASK       8'h43
`define TFC_REG_REMOTE     8'h44

`define TFC_CONFIG_RESET   8'h00
`define TFC_MASK_RESET     8'h00
`define TFC_STATUS_RESET   8'h00
`define TFC_BYTE_ZERO      8'h00

`define TFC_CFG_INT_EN     1
`define TFC_CFG_FAN_OFF    2
`define TFC_CFG_GPI_POL    3
`define TFC_ST_TRIP        0
`define TFC_ST_HOT         1
`define TFC_ST_GPI         4
`define TFC_RF_RESET       0
`define TFC_RF_OFF         1

`define TFC_FAN_FULL       8'hff
`define TFC_FAN_STOP       8'h00

`endif

// File: rtl/tfc_pkg.sv
// Types shared by the thermal fan control pin block
`default_nettype none
package tfc_pkg;
   typedef logic [7:0] tfc_byte_t;
   typedef enum logic [2:0] {
      TFC_IDLE, TFC_RX, TFC_ACK, TFC_TX, TFC_TXACK
   } tfc_smb_state_e;
endpackage : tfc_pkg
`default_nettype wire

// File: rtl/tfc_smb_if.sv
// Register access carrier between the serial slave and the control core
`timescale 1ns/100ps
`default_nettype none
interface tfc_smb_if;
   import tfc_pkg::*;
   tfc_byte_t ptr;
   logic      wr_stb;
   tfc_byte_t wr_data;
   logic      rd_stb;
   tfc_byte_t rd_data;
   modport slave (output ptr, output wr_stb, output wr_data, output rd_stb, input rd_data);
   modport core  (input ptr, input wr_stb, input wr_data, input rd_stb, output rd_data);
endinterface : tfc_smb_if
`default_nettype wire

// File: rtl/tfc_smb_slave.sv
// Serial management bus slave: address match, pointer load, register write and read
`timescale 1ns/100ps
`default_nettype none
`include "tfc_params.svh"
module tfc_smb_slave
   import tfc_pkg::*;
(
   input  wire logic  clk_i,
   input  wire logic  rst_n_i,
   input  wire logic  scl_i,
   input  wire logic  sda_i,
   output logic       sda_oe_n_o,
   tfc_smb_if.slave   bus
);
   tfc_smb_state_e state, next_state;
   logic [2:0]     cnt, next_cnt;
   logic [1:0]     idx, next_idx;
   tfc_byte_t      sh, next_sh, ptr, next_ptr, wr_data, next_wr_data;
   logic           scl_q, sda_q, rw, next_rw, done, next_done, ack_seen, next_ack_seen;
   logic           wr_stb, next_wr_stb, next_rd_stb, next_sda_oe_n;
   logic           start, stop, rise, fall;

   assign start = scl_i & scl_q & sda_q & ~sda_i;
   assign stop  = scl_i & scl_q & ~sda_q & sda_i;
   assign rise  = scl_i & ~scl_q;
   assign fall  = ~scl_i & scl_q;
   assign bus.ptr     = ptr;
   assign bus.wr_stb  = wr_stb;
   assign bus.wr_data = wr_data;
   // Unregistered: the status clear lands on the capture edge, so an event there is kept
   assign bus.rd_stb  = next_rd_stb;

   always_comb begin
      next_state = state;
      next_cnt = cnt;
      next_idx = idx;
      next_sh = sh;
      next_ptr = ptr;
      next_wr_data = wr_data;
      next_rw = rw;
      next_done = done;
      next_ack_seen = ack_seen;
      next_wr_stb = 1'b0;
      next_rd_stb = 1'b0;
      next_sda_oe_n = sda_oe_n_o;
      if (start) begin
         next_state = TFC_RX;
         next_cnt = 3'h0;
         next_idx = 2'h0;
         next_done = 1'b0;
         next_sda_oe_n = 1'b1;
      end else if (stop) begin
         next_state = TFC_IDLE;
         next_sda_oe_n = 1'b1;
      end else begin
         case (state)
            TFC_RX: begin
               if (rise) begin
                  next_sh = {sh[6:0], sda_i};
                  next_cnt = cnt + 3'h1;
                  next_done = (cnt == 3'h7);
               end else if (fall && done) begin
                  next_done = 1'b0;
                  next_state = TFC_ACK;
                  next_sda_oe_n = 1'b0;
                  if (idx == 2'h0) begin
                     next_rw = sh[0];
                     if (sh[7:1] != `TFC_SMB_ADDR) begin
                        // Not our address: stay silent until the next start
                        next_state = TFC_IDLE;
                        next_sda_oe_n = 1'b1;
                     end
                  end else if (idx == 2'h1) begin
                     next_ptr = sh;
                  end else begin
                     next_wr_data = sh;
                     next_wr_stb = 1'b1;
                  end
               end
            end
            TFC_ACK: begin
               if (fall) begin
                  next_cnt = 3'h0;
                  if (rw) begin
                     next_state = TFC_TX;
                     next_sh = bus.rd_data;
                     next_rd_stb = 1'b1;
                     next_sda_oe_n = bus.rd_data[7];
                  end else begin
                     next_state = TFC_RX;
                     next_sda_oe_n = 1'b1;
                     // Extra data bytes keep landing in the pointed register
                     next_idx = (idx == 2'h2) ? idx : idx + 2'h1;
                  end
               end
            end
            TFC_TX: begin
               if (fall) begin
                  if (cnt == 3'h7) begin
                     next_state = TFC_TXACK;
                     next_sda_oe_n = 1'b1;
                  end else begin
                     next_cnt = cnt + 3'h1;
                     next_sh = {sh[6:0], 1'b0};
                     next_sda_oe_n = sh[6];
                  end
               end
            end
            TFC_TXACK: begin
               if (rise) begin
                  next_ack_seen = ~sda_i;
               end else if (fall) begin
                  next_cnt = 3'h0;
                  if (ack_seen) begin
                     next_state = TFC_TX;
                     next_sh = bus.rd_data;
                     next_rd_stb = 1'b1;
                     next_sda_oe_n = bus.rd_data[7];
                  end else begin
                     next_state = TFC_IDLE;
                  end
               end
            end
            default: begin
               next_state = TFC_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state <= TFC_IDLE;
         cnt <= 3'h0;
         idx <= 2'h0;
         sh <= `TFC_BYTE_ZERO;
         ptr <= `TFC_BYTE_ZERO;
         wr_data <= `TFC_BYTE_ZERO;
         rw <= 1'b0;
         done <= 1'b0;
         ack_seen <= 1'b0;
         wr_stb <= 1'b0;
         sda_oe_n_o <= 1'b1;
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end else begin
         state <= next_state;
         cnt <= next_cnt;
         idx <= next_idx;
         sh <= next_sh;
         ptr <= next_ptr;
         wr_data <= next_wr_data;
         rw <= next_rw;
         done <= next_done;
         ack_seen <= next_ack_seen;
         wr_stb <= next_wr_stb;
         sda_oe_n_o <= next_sda_oe_n;
         scl_q <= scl_i;
         sda_q <= sda_i;
      end
   end
endmodule : tfc_smb_slave
`default_nettype wire

// File: rtl/tfc_core.sv
// Fan, thermal alert, remote control and board test pin logic with its serial slave
//
// Contract
// - Fan-off request pin pulls low to ask for fan shut-off, independent of speed.
// - General input has selectable polarity; when active it sets status bit 4.
// - Auxiliary reset input driven low resets the whole block.
// - Main-power-lost low turns fan speed off and clears remote power-off.
// - A remote function write with bit 0 set pulses the remote reset pin low.
// - High on the fan-speed/test pin selects board connectivity tree test.
// - Outside tree test the shared pin carries the fan speed output.
// - First over-temperature output goes low whenever a setpoint is violated outside tree test.
// - While the first over-temperature output is low outside tree test, fan runs full speed unless main-power-lost is low.
// - In tree test the first over-temperature pin carries the tree result.
// - Second open-drain over-temperature output carries the same indication.
// - A remote function write with bit 1 set drives the remote power-off output high.
// - Remote power-off stays high until main-power-lost goes low.
// - Trip point violations are signalled on the system interrupt pin.
// - Interrupt pin works only while configuration bit 1 is set; reset clears it.
// - Serial slave answers at 7-bit address 0101110 after power-up.
// - First written byte loads the pointer; a second byte writes that register.
// - The remote function register drives the remote reset and power-off pins.
`timescale 1ns/100ps
`default_nettype none
`include "tfc_params.svh"
module tfc_core
   import tfc_pkg::*;
#(
   parameter int unsigned RRST_CYCLES = `TFC_RRST_CYCLES,
   parameter int unsigned CNT_W       = 8
)(
   input  wire logic       clk_i,
   input  wire logic       nrst_i,
   input  wire logic       aux_reset_n_i,
   input  wire logic       main_power_lost_n_i,
   input  wire logic       general_input_pin_i,
   input  wire logic       fan_speed_or_tree_test_in_i,
   input  wire logic       overtemp_event_i,
   input  wire logic       trip_event_i,
   input  wire logic [7:0] fan_demand_i,
   input  wire logic       scl_i,
   input  wire logic       sda_i,
   output logic            sda_oe_n_o,
   output logic [7:0]      fan_speed_analog_out_o,
   output logic            fan_off_oe_n_o,
   output logic            overtemp_a_or_tree_out_o,
   output logic            overtemp_b_n_oe_n_o,
   output logic            remote_reset_oe_n_o,
   output logic            remote_off_o,
   output logic            int_oe_n_o
);
   localparam int TREE_W = 5;

   logic             rst_raw_n, rst_n;
   logic [1:0]       rst_sync;
   tfc_byte_t        cfg, next_cfg, mask, next_mask, status, next_status;
   logic [CNT_W-1:0] rrst_cnt, next_rrst_cnt;
   logic             roff, next_roff, gpi_active, rrst_load, test_mode;
   logic [TREE_W-1:0] tree_in, tree_chain;
   logic [7:0]       next_fan;
   logic             next_fan_off_oe_n, next_ota, next_otb, next_rrst_oe_n, next_int_oe_n;
   logic [15:0]      low_len;

   tfc_smb_if smb ();

   tfc_smb_slave u_slave (
      .clk_i      (clk_i),
      .rst_n_i    (rst_n),
      .scl_i      (scl_i),
      .sda_i      (sda_i),
      .sda_oe_n_o (sda_oe_n_o),
      .bus        (smb.slave)
   );

   // Either reset source asserts at once; release is retimed to the clock
   assign rst_raw_n = nrst_i & aux_reset_n_i;
   always_ff @(posedge clk_i or negedge rst_raw_n) begin
      if (!rst_raw_n) begin
         rst_sync <= 2'b00;
      end else begin
         rst_sync <= {rst_sync[0], 1'b1};
      end
   end
   assign rst_n = rst_sync[1];

   assign test_mode  = fan_speed_or_tree_test_in_i;
   assign gpi_active = (general_input_pin_i == cfg[`TFC_CFG_GPI_POL]);
   assign rrst_load  = smb.wr_stb && (smb.ptr == `TFC_REG_REMOTE)
                       && smb.wr_data[`TFC_RF_RESET];

   // Board connectivity chain through the digital inputs
   assign tree_in = {sda_i, scl_i, main_power_lost_n_i, aux_reset_n_i, general_input_pin_i};
   assign tree_chain[0] = tree_in[0];
   for (genvar i = 1; i < TREE_W; i++) begin : g_tree
      assign tree_chain[i] = ~(tree_chain[i-1] & tree_in[i]);
   end

   always_comb begin
      smb.rd_data = `TFC_BYTE_ZERO;
      if (smb.ptr == `TFC_REG_CONFIG) begin
         smb.rd_data = cfg;
      end else if (smb.ptr == `TFC_REG_STATUS) begin
         smb.rd_data = status;
      end else if (smb.ptr == `TFC_REG_MASK) begin
         smb.rd_data = mask;
      end else if (smb.ptr == `TFC_REG_REMOTE) begin
         smb.rd_data = {6'h00, roff, 1'b0};
      end
   end

   always_comb begin
      next_cfg = cfg;
      next_mask = mask;
      next_roff = roff;
      next_rrst_cnt = rrst_cnt;
      next_status = status;
      // Reading status clears it; a same-cycle event is set again below
      if (smb.rd_stb && (smb.ptr == `TFC_REG_STATUS)) begin
         next_status = `TFC_STATUS_RESET;
      end
      if (gpi_active) begin
         next_status[`TFC_ST_GPI] = 1'b1;
      end
      if (trip_event_i) begin
         next_status[`TFC_ST_TRIP] = 1'b1;
      end
      if (overtemp_event_i) begin
         next_status[`TFC_ST_HOT] = 1'b1;
      end
      if (rrst_cnt != '0) begin
         next_rrst_cnt = rrst_cnt - 1'b1;
      end
      if (smb.wr_stb) begin
         if (smb.ptr == `TFC_REG_CONFIG) begin
            next_cfg = smb.wr_data;
         end else if (smb.ptr == `TFC_REG_MASK) begin
            next_mask = smb.wr_data;
         end else if (smb.ptr == `TFC_REG_REMOTE) begin
            if (smb.wr_data[`TFC_RF_RESET]) begin
               next_rrst_cnt = CNT_W'(RRST_CYCLES);
            end
            if (smb.wr_data[`TFC_RF_OFF]) begin
               next_roff = 1'b1;
            end
         end
      end
      // Power loss overrides a power-off command in the same cycle
      if (!main_power_lost_n_i) begin
         next_roff = 1'b0;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         cfg <= `TFC_CONFIG_RESET;
         mask <= `TFC_MASK_RESET;
         status <= `TFC_STATUS_RESET;
         roff <= 1'b0;
         rrst_cnt <= '0;
      end else begin
         cfg <= next_cfg;
         mask <= next_mask;
         status <= next_status;
         roff <= next_roff;
         rrst_cnt <= next_rrst_cnt;
      end
   end

   always_comb begin
      next_fan = fan_demand_i;
      if (!main_power_lost_n_i || test_mode) begin
         next_fan = `TFC_FAN_STOP;
      end else if (overtemp_event_i) begin
         next_fan = `TFC_FAN_FULL;
      end
      next_fan_off_oe_n = ~next_cfg[`TFC_CFG_FAN_OFF];
      next_ota = test_mode ? tree_chain[TREE_W-1] : ~overtemp_event_i;
      next_otb = ~overtemp_event_i;
      next_rrst_oe_n = (next_rrst_cnt == '0);
      next_int_oe_n = ~(next_cfg[`TFC_CFG_INT_EN] && ((next_status & ~next_mask) != '0));
   end

   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         fan_speed_analog_out_o <= `TFC_FAN_STOP;
         fan_off_oe_n_o <= 1'b1;
         overtemp_a_or_tree_out_o <= 1'b1;
         overtemp_b_n_oe_n_o <= 1'b1;
         remote_reset_oe_n_o <= 1'b1;
         remote_off_o <= 1'b0;
         int_oe_n_o <= 1'b1;
      end else begin
         fan_speed_analog_out_o <= next_fan;
         fan_off_oe_n_o <= next_fan_off_oe_n;
         overtemp_a_or_tree_out_o <= next_ota;
         overtemp_b_n_oe_n_o <= next_otb;
         remote_reset_oe_n_o <= next_rrst_oe_n;
         remote_off_o <= next_roff;
         int_oe_n_o <= next_int_oe_n;
      end
   end

   // Helper for the pulse length check: low cycles since the last load
   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         low_len <= 16'h0000;
      end else if (rrst_load) begin
         low_len <= 16'h0000;
      end else if (!remote_reset_oe_n_o) begin
         low_len <= low_len + 16'h0001;
      end
   end

   a_rrst_pulse_len: assert property (@(posedge clk_i) disable iff (!rst_n)
      $rose(remote_reset_oe_n_o) |-> (low_len == 16'(RRST_CYCLES)))
      else $error("remote reset pulse has wrong length");
   a_rrst_start: assert property (@(posedge clk_i) disable iff (!rst_n)
      rrst_load |=> (!remote_reset_oe_n_o)[*8])
      else $error("remote reset pulse did not start");
   a_fan_hot_full: assert property (@(posedge clk_i) disable iff (!rst_n)
      (overtemp_event_i && !test_mode && main_power_lost_n_i)
      |=> (fan_speed_analog_out_o == `TFC_FAN_FULL))
      else $error("fan not at full speed while hot");
   a_power_lost_off: assert property (@(posedge clk_i) disable iff (!rst_n)
      !main_power_lost_n_i |=> (fan_speed_analog_out_o == `TFC_FAN_STOP) && !remote_off_o)
      else $error("power loss did not stop fan or clear power-off");
   a_roff_hold: assert property (@(posedge clk_i) disable iff (!rst_n)
      (remote_off_o && main_power_lost_n_i) |=> remote_off_o)
      else $error("remote power-off dropped without power loss");
   a_int_gated: assert property (@(posedge clk_i) disable iff (!rst_n)
      !int_oe_n_o |-> $past(next_cfg[`TFC_CFG_INT_EN]))
      else $error("interrupt pin active while disabled");
   a_tree_route: assert property (@(posedge clk_i) disable iff (!rst_n)
      test_mode |=> (overtemp_a_or_tree_out_o == $past(tree_chain[TREE_W-1])))
      else $error("tree result not routed in test mode");
   a_therm_pair: assert property (@(posedge clk_i) disable iff (!rst_n)
      !$past(test_mode) |-> (overtemp_a_or_tree_out_o == overtemp_b_n_oe_n_o))
      else $error("second over-temperature output disagrees");
   a_gpi_sets: assert property (@(posedge clk_i) disable iff (!rst_n)
      gpi_active |=> status[`TFC_ST_GPI])
      else $error("active general input did not set status");
   a_fan_off_req: assert property (@(posedge clk_i) disable iff (!rst_n)
      cfg[`TFC_CFG_FAN_OFF] |-> !fan_off_oe_n_o)
      else $error("fan-off request not driven");
endmodule : tfc_core
`default_nettype wire

// File: verif/tfc_host_model.sv
// Serial management host model that drives the block's bus pins
`timescale 1ns/100ps
`default_nettype none
`include "tfc_params.svh"
module tfc_host_model (
   input  wire logic clk_i,
   input  wire logic sda_oe_n_i,
   output logic      scl_o,
   output logic      sda_o,
   output logic      sda_line_o
);
   // Pull-up on the line: high unless one party pulls it low
   assign sda_line_o = sda_o & sda_oe_n_i;
   initial begin
      scl_o = 1'b1;
      sda_o = 1'b1;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge clk_i);
   endtask : tick
   // Data moves only while the clock is low; sampled mid-high
   task automatic put_bit(input logic b, output logic r);
      sda_o <= b;
      tick(2);
      scl_o <= 1'b1;
      tick(2);
      r = sda_line_o;
      tick(2);
      scl_o <= 1'b0;
      tick(2);
   endtask : put_bit
   task automatic start_cond();
      sda_o <= 1'b1;
      tick(2);
      scl_o <= 1'b1;
      tick(3);
      sda_o <= 1'b0;
      tick(3);
      scl_o <= 1'b0;
      tick(2);
   endtask : start_cond
   task automatic stop_cond();
      sda_o <= 1'b0;
      tick(2);
      scl_o <= 1'b1;
      tick(3);
      sda_o <= 1'b1;
      tick(4);
   endtask : stop_cond
   task automatic send_byte(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) put_bit(d[i], r);
      put_bit(1'b1, r);
      ack = ~r;
   endtask : send_byte
   task automatic write_reg(input logic [6:0] adr, input logic [7:0] p, input logic [7:0] d,
                            output logic ack);
      logic a0, a1, a2;
      start_cond();
      send_byte({adr, 1'b0}, a0);
      send_byte(p, a1);
      send_byte(d, a2);
      stop_cond();
      ack = a0 & a1 & a2;
   endtask : write_reg
   task automatic read_reg(input logic [7:0] p, output logic [7:0] d);
      logic a, r;
      start_cond();
      send_byte({`TFC_SMB_ADDR, 1'b0}, a);
      send_byte(p, a);
      start_cond();
      send_byte({`TFC_SMB_ADDR, 1'b1}, a);
      for (int i = 7; i >= 0; i--) begin
         put_bit(1'b1, r);
         d[i] = r;
      end
      // No acknowledge ends the read
      put_bit(1'b1, r);
      stop_cond();
   endtask : read_reg
endmodule : tfc_host_model
`default_nettype wire

// File: verif/thermal_fan_control_pins_bench.sv
// Self-checking bench for the thermal fan control pin block
`timescale 1ns/100ps
`default_nettype none
`include "tfc_params.svh"
module thermal_fan_control_pins_bench;
   import tfc_pkg::*;
   localparam int unsigned RRST  = 20;
   // Ceiling is several times the expected run length
   localparam int          LIMIT = 40000;
   logic       clk_i, nrst_i, aux_n, mpl_n, gin, test_in, hot, trip;
   logic [7:0] demand, fan, rdv;
   logic       scl, sda_h, sda, sda_oe_n, fan_off_n, ota, otb_n, rrst_n, roff, int_n;
   int         errors, comparisons, cycles;
   int         low_cnt = 0;

   tfc_core #(.RRST_CYCLES(RRST)) u_dut (
      .clk_i(clk_i), .nrst_i(nrst_i), .aux_reset_n_i(aux_n), .main_power_lost_n_i(mpl_n),
      .general_input_pin_i(gin), .fan_speed_or_tree_test_in_i(test_in),
      .overtemp_event_i(hot), .trip_event_i(trip), .fan_demand_i(demand),
      .scl_i(scl), .sda_i(sda), .sda_oe_n_o(sda_oe_n), .fan_speed_analog_out_o(fan),
      .fan_off_oe_n_o(fan_off_n), .overtemp_a_or_tree_out_o(ota),
      .overtemp_b_n_oe_n_o(otb_n), .remote_reset_oe_n_o(rrst_n),
      .remote_off_o(roff), .int_oe_n_o(int_n));
   tfc_host_model u_host (.clk_i(clk_i), .sda_oe_n_i(sda_oe_n), .scl_o(scl),
      .sda_o(sda_h), .sda_line_o(sda));

   always #50 clk_i = ~clk_i;
   // Counts on its own, so a pulse that outlasts the write task is still measured
   always @(posedge clk_i) begin
      if (!rrst_n) low_cnt <= low_cnt + 1;
   end

   task automatic conclude();
      if (errors == 0 && comparisons > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : conclude
   task automatic watchdog();
      while (cycles < LIMIT) begin
         tick(1);
         cycles++;
      end
      errors++;
      $display("unexpected at %0t: run did not finish in time", $time);
   endtask : watchdog
   task automatic tick(input int n);
      repeat (n) @(posedge clk_i);
   endtask : tick
   task automatic chk(input logic [7:0] g, input logic [7:0] e, input string w);
      comparisons++;
      if (g !== e) begin
         errors++;
         $display("unexpected at %0t: %s got %h want %h", $time, w, g, e);
      end
   endtask : chk
   task automatic chk1(input logic g, input logic e, input string w);
      chk({7'h00, g}, {7'h00, e}, w);
   endtask : chk1
   task automatic wr(input logic [7:0] p, input logic [7:0] d);
      logic a;
      u_host.write_reg(`TFC_SMB_ADDR, p, d, a);
      chk1(a, 1'b1, "write ack");
      tick(3);
   endtask : wr
   task automatic rd(input logic [7:0] p, output logic [7:0] d);
      u_host.read_reg(p, d);
      tick(2);
   endtask : rd

   task automatic t_pins();
      demand <= 8'h5a;
      tick(3);
      chk(fan, 8'h5a, "fan demand");
      chk1(ota, 1'b1, "ota cool");
      hot <= 1'b1;
      tick(3);
      chk(fan, `TFC_FAN_FULL, "fan full");
      chk1(ota, 1'b0, "ota hot");
      chk1(otb_n, 1'b0, "otb hot");
      hot <= 1'b0;
      tick(3);
      chk1(otb_n, 1'b1, "otb cool");
   endtask : t_pins
   task automatic t_tree();
      logic e;
      test_in <= 1'b1;
      for (int i = 0; i < 4; i++) begin
         gin <= i[0];
         mpl_n <= i[1];
         tick(3);
         e = ~(~(~(~(gin & aux_n) & mpl_n) & scl) & sda);
         chk(fan, `TFC_FAN_STOP, "fan in test");
         chk1(ota, e, "tree result");
      end
      test_in <= 1'b0;
      mpl_n <= 1'b1;
      gin <= 1'b0;
      tick(3);
      chk(fan, 8'h5a, "fan after test");
   endtask : t_tree
   task automatic t_fan_off();
      wr(`TFC_REG_CONFIG, 8'h04);
      chk1(fan_off_n, 1'b0, "fan off req");
      chk(fan, 8'h5a, "fan kept");
      wr(`TFC_REG_CONFIG, 8'h00);
      chk1(fan_off_n, 1'b1, "fan off rel");
   endtask : t_fan_off
   task automatic t_gin();
      wr(`TFC_REG_CONFIG, 8'h0a);
      rd(`TFC_REG_STATUS, rdv);
      chk1(int_n, 1'b1, "int idle");
      gin <= 1'b1;
      tick(3);
      chk1(int_n, 1'b0, "int high pol");
      gin <= 1'b0;
      rd(`TFC_REG_STATUS, rdv);
      chk(rdv, 8'h10, "status input");
      tick(3);
      chk1(int_n, 1'b1, "int cleared");
      wr(`TFC_REG_CONFIG, 8'h02);
      chk1(int_n, 1'b0, "int low pol");
      wr(`TFC_REG_CONFIG, 8'h00);
      chk1(int_n, 1'b1, "int disabled");
      gin <= 1'b1;
      rd(`TFC_REG_STATUS, rdv);
   endtask : t_gin
   task automatic t_trip();
      wr(`TFC_REG_CONFIG, 8'h02);
      trip <= 1'b1;
      tick(3);
      chk1(int_n, 1'b0, "int trip");
      wr(`TFC_REG_MASK, 8'h01);
      chk1(int_n, 1'b1, "int masked");
      trip <= 1'b0;
      wr(`TFC_REG_MASK, 8'h00);
      rd(`TFC_REG_STATUS, rdv);
      chk(rdv, 8'h01, "status trip");
      tick(3);
      chk1(int_n, 1'b1, "int released");
   endtask : t_trip
   task automatic t_remote();
      logic a;
      int   base;
      u_host.write_reg(7'h2f, `TFC_REG_REMOTE, 8'h02, a);
      chk1(a, 1'b0, "foreign address");
      chk1(roff, 1'b0, "foreign ignored");
      base = low_cnt;
      wr(`TFC_REG_REMOTE, 8'h01);
      tick(RRST + 10);
      chk(8'(low_cnt - base), 8'(RRST), "pulse length");
      chk1(rrst_n, 1'b1, "pulse end");
      wr(`TFC_REG_REMOTE, 8'h02);
      chk1(roff, 1'b1, "power off set");
      tick(50);
      chk1(roff, 1'b1, "power off held");
      rd(`TFC_REG_REMOTE, rdv);
      chk(rdv & 8'h02, 8'h02, "power off bit");
      mpl_n <= 1'b0;
      tick(3);
      chk1(roff, 1'b0, "power lost off");
      chk(fan, `TFC_FAN_STOP, "power lost fan");
      mpl_n <= 1'b1;
      tick(3);
      chk1(roff, 1'b0, "stays clear");
   endtask : t_remote
   task automatic t_aux();
      wr(`TFC_REG_REMOTE, 8'h02);
      wr(`TFC_REG_CONFIG, 8'h04);
      aux_n <= 1'b0;
      tick(2);
      chk1(roff, 1'b0, "aux off");
      chk1(fan_off_n, 1'b1, "aux fan req");
      aux_n <= 1'b1;
      tick(4);
      chk1(fan_off_n, 1'b1, "config reset");
   endtask : t_aux

   initial begin
      clk_i = 1'b0;
      nrst_i = 1'b0;
      aux_n = 1'b1;
      mpl_n = 1'b1;
      gin = 1'b1;
      test_in = 1'b0;
      hot = 1'b0;
      trip = 1'b0;
      demand = 8'h00;
      errors = 0;
      comparisons = 0;
      cycles = 0;
      tick(4);
      chk1(roff, 1'b0, "reset off");
      chk1(int_n, 1'b1, "reset int");
      chk1(rrst_n, 1'b1, "reset pulse");
      nrst_i <= 1'b1;
      // Whichever ends first, the scenarios or the ceiling, leads to the report
      fork
         watchdog();
         begin
            tick(4);
            t_pins();
            t_tree();
            t_fan_off();
            t_gin();
            t_trip();
            t_remote();
            t_aux();
         end
      join_any
      conclude();
   end
endmodule : thermal_fan_control_pins_bench
`default_nettype wire
